// file: wdtu_pkg.sv
// Watchdog timer unit: shared constants, types and the limit function.
// Assumes one system clock; the slow oscillator arrives as a pin.
package wdtu_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the 4-bit bus address
    localparam logic [3:0] WDTU_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] WDTU_STAT_OFFSET = 4'h4;

    // Control register fields
    localparam int WDTU_SWEN_BIT = 0;
    localparam int WDTU_PS_LSB = 1;
    localparam int WDTU_PS_MSB = 5;
    localparam logic [4:0] WDTU_PS_RESET = 5'h0b;
    localparam logic WDTU_SWEN_RESET = 1'h0;
    localparam logic [4:0] WDTU_PS_MAX = 5'h12;

    // Status register fields
    localparam int WDTU_STAT_TO_BIT = 0;
    localparam int WDTU_STAT_PD_BIT = 1;
    localparam int WDTU_STAT_SLEEP_BIT = 2;
    localparam int WDTU_STAT_ACTIVE_BIT = 3;
    localparam int WDTU_STAT_CNT_LSB = 8;
    localparam int WDTU_STAT_CNT_MSB = 30;

    // Counter
    localparam int WDTU_CNT_W = 23;
    localparam logic [22:0] WDTU_MIN_RATIO = 23'h000020;
    localparam logic [22:0] WDTU_MIN_LIMIT = 23'h00001f;

    // Bus responses
    localparam logic [1:0] WDTU_RESP_OKAY = 2'h0;
    localparam logic [1:0] WDTU_RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        WDTU_MODE_OFF = 2'h0,
        WDTU_MODE_SW = 2'h1,
        WDTU_MODE_AWAKE = 2'h2,
        WDTU_MODE_ON = 2'h3
    } wdtu_mode_type;

    typedef enum logic [1:0] {
        WDTU_ST_AWAKE = 2'h1,
        WDTU_ST_ASLEEP = 2'h2
    } wdtu_state_type;

    // Last count value before time-out for a period code
    function automatic logic [22:0] wdtu_limit(input logic [4:0] ps);
        logic [22:0] lim;
        lim = WDTU_MIN_LIMIT;
        if (ps <= WDTU_PS_MAX) begin
            lim = (WDTU_MIN_RATIO << ps) - 23'h000001;
        end
        return lim;
    endfunction : wdtu_limit

endpackage : wdtu_pkg

// file: wdtu_counter.sv
// Watchdog prescale counter, advanced by slow-oscillator ticks.
// Assumes ticks and clears are synchronous to i_clk.
`timescale 1ns/10ps
module wdtu_counter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_tick,
    input wire logic i_clear,
    input wire logic [4:0] i_period_select,
    // Result
    output logic [22:0] o_count,
    output logic o_timeout
);

    logic [22:0] next_count;
    logic next_timeout;
    logic [22:0] limit;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        limit = wdtu_pkg::wdtu_limit(i_period_select);
        next_count = o_count;
        next_timeout = 1'b0;
        if (i_clear) begin
            next_count = '0;
        end else if (i_tick) begin
            // Greater-or-equal covers a period shortened mid-count
            if (o_count >= limit) begin
                next_count = '0;
                next_timeout = 1'b1;
            end else begin
                next_count = o_count + 23'h000001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_count <= '0;
            o_timeout <= 1'b0;
        end else begin
            o_count <= next_count;
            o_timeout <= next_timeout;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_timeout_at_limit;
        o_timeout |-> $past(o_count) >= wdtu_pkg::wdtu_limit($past(i_period_select));
    endproperty
    a_timeout_at_limit: assert property (p_timeout_at_limit)
        else $error("time-out before selected ratio");

    property p_reserved_min;
        (i_period_select > wdtu_pkg::WDTU_PS_MAX && i_tick && !i_clear
            && o_count == wdtu_pkg::WDTU_MIN_LIMIT) |=> o_timeout;
    endproperty
    a_reserved_min: assert property (p_reserved_min)
        else $error("reserved code not at 1:32");

    property p_clear_zero;
        i_clear |=> (o_count == 23'h000000) && !o_timeout;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("count not cleared");

endmodule : wdtu_counter

// file: wdtu_watchdog.sv
// Watchdog timer unit top: AXI4-Lite registers, mode logic, sleep state.
// Assumes core events are one-cycle pulses on i_clk; osc is a raw pin.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module wdtu_watchdog (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // AXI4-Lite write address and data
    input wire logic [3:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Oscillator and configuration
    input wire logic i_low_freq_internal_osc,
    input wire logic [1:0] i_wd_mode_cfg,
    input wire logic i_crystal_mode,
    // Core events
    input wire logic i_clear_watchdog_instr,
    input wire logic i_sleep_enter,
    input wire logic i_sleep_exit,
    input wire logic i_osc_fail,
    input wire logic i_osc_startup_timer,
    // Results
    output logic o_wdt_reset,
    output logic o_wake,
    output logic o_timeout_flag_n,
    output logic o_powerdown_flag_n,
    output logic o_asleep
);

    // One-hot select: bit 0 control, bit 1 status
    function automatic logic [1:0] reg_select(input logic [3:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr == wdtu_pkg::WDTU_CTRL_OFFSET) begin
            sel = 2'h1;
        end else if (addr == wdtu_pkg::WDTU_STAT_OFFSET) begin
            sel = 2'h2;
        end
        return sel;
    endfunction : reg_select

    ////////////////////////////////////////////////////////////////////
    // Slow oscillator synchroniser and edge detect
    logic lf_meta;
    logic lf_sync;
    logic lf_prev;
    logic lf_tick;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lf_meta <= 1'b0;
            lf_sync <= 1'b0;
            lf_prev <= 1'b0;
        end else begin
            lf_meta <= i_low_freq_internal_osc;
            lf_sync <= lf_meta;
            lf_prev <= lf_sync;
        end
    end

    assign lf_tick = lf_sync & ~lf_prev;

    ////////////////////////////////////////////////////////////////////
    // Control register
    logic [4:0] wd_period_select;
    logic sw_wd_enable;
    logic [4:0] next_wd_period_select;
    logic next_sw_wd_enable;

    ////////////////////////////////////////////////////////////////////
    // Mode decode and counter clears
    wdtu_pkg::wdtu_state_type state;
    wdtu_pkg::wdtu_state_type next_state;
    logic wd_active;
    logic osc_hold;
    logic enter_take;
    logic exit_take;
    logic cnt_clear;
    logic cnt_timeout;
    logic [22:0] cnt_value;

    always_comb begin
        unique case (wdtu_pkg::wdtu_mode_type'(i_wd_mode_cfg))
            wdtu_pkg::WDTU_MODE_OFF: wd_active = 1'b0;
            wdtu_pkg::WDTU_MODE_SW: wd_active = sw_wd_enable;
            wdtu_pkg::WDTU_MODE_AWAKE: wd_active = (state == wdtu_pkg::WDTU_ST_AWAKE);
            wdtu_pkg::WDTU_MODE_ON: wd_active = 1'b1;
        endcase
    end

    assign osc_hold = i_osc_startup_timer & i_crystal_mode;
    assign enter_take = i_sleep_enter & (state == wdtu_pkg::WDTU_ST_AWAKE);
    assign exit_take = (state == wdtu_pkg::WDTU_ST_ASLEEP) & (i_sleep_exit | cnt_timeout);
    // Divider selection is deliberately not a clear source
    assign cnt_clear = i_clear_watchdog_instr | enter_take | exit_take
        | i_osc_fail | ~wd_active | osc_hold;

    wdtu_counter u_counter (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tick(lf_tick),
        .i_clear(cnt_clear),
        .i_period_select(wd_period_select),
        .o_count(cnt_value),
        .o_timeout(cnt_timeout)
    );

    ////////////////////////////////////////////////////////////////////
    // Sleep state and status flags
    logic next_timeout_flag_n;
    logic next_powerdown_flag_n;
    logic next_wdt_reset;
    logic next_wake;

    always_comb begin
        next_state = state;
        next_timeout_flag_n = o_timeout_flag_n;
        next_powerdown_flag_n = o_powerdown_flag_n;
        next_wdt_reset = 1'b0;
        next_wake = 1'b0;
        unique case (state)
            wdtu_pkg::WDTU_ST_AWAKE: begin
                if (cnt_timeout) begin
                    next_wdt_reset = 1'b1;
                    next_timeout_flag_n = 1'b0;
                end else if (i_sleep_enter) begin
                    next_state = wdtu_pkg::WDTU_ST_ASLEEP;
                    next_powerdown_flag_n = 1'b0;
                    next_timeout_flag_n = 1'b1;
                end else if (i_clear_watchdog_instr) begin
                    next_powerdown_flag_n = 1'b1;
                    next_timeout_flag_n = 1'b1;
                end
            end
            wdtu_pkg::WDTU_ST_ASLEEP: begin
                if (cnt_timeout) begin
                    next_state = wdtu_pkg::WDTU_ST_AWAKE;
                    next_wake = 1'b1;
                    next_timeout_flag_n = 1'b0;
                end else if (i_sleep_exit) begin
                    next_state = wdtu_pkg::WDTU_ST_AWAKE;
                end
            end
            default: begin
                next_state = wdtu_pkg::WDTU_ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= wdtu_pkg::WDTU_ST_AWAKE;
            o_timeout_flag_n <= 1'b1;
            o_powerdown_flag_n <= 1'b1;
            o_wdt_reset <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            state <= next_state;
            o_timeout_flag_n <= next_timeout_flag_n;
            o_powerdown_flag_n <= next_powerdown_flag_n;
            o_wdt_reset <= next_wdt_reset;
            o_wake <= next_wake;
        end
    end

    assign o_asleep = state[1];

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic [3:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic [1:0] wr_sel;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = o_s_axi_bvalid;
        next_bresp = o_s_axi_bresp;
        next_wd_period_select = wd_period_select;
        next_sw_wd_enable = sw_wd_enable;
        wr_sel = reg_select(aw_addr);
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = i_s_axi_wdata;
            next_w_strb = i_s_axi_wstrb;
        end
        if (o_s_axi_bvalid && i_s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !o_s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wr_sel == 2'h0) ? wdtu_pkg::WDTU_RESP_SLVERR
                : wdtu_pkg::WDTU_RESP_OKAY;
            if (wr_sel[0] && w_strb[0]) begin
                next_wd_period_select = w_data[wdtu_pkg::WDTU_PS_MSB:wdtu_pkg::WDTU_PS_LSB];
                next_sw_wd_enable = w_data[wdtu_pkg::WDTU_SWEN_BIT];
            end
        end
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready = ~next_w_held & ~next_bvalid;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= wdtu_pkg::WDTU_RESP_OKAY;
            wd_period_select <= wdtu_pkg::WDTU_PS_RESET;
            sw_wd_enable <= wdtu_pkg::WDTU_SWEN_RESET;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            o_s_axi_awready <= next_awready;
            o_s_axi_wready <= next_wready;
            o_s_axi_bvalid <= next_bvalid;
            o_s_axi_bresp <= next_bresp;
            wd_period_select <= next_wd_period_select;
            sw_wd_enable <= next_sw_wd_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [1:0] rd_sel;

    always_comb begin
        next_rvalid = o_s_axi_rvalid;
        next_rdata = o_s_axi_rdata;
        next_rresp = o_s_axi_rresp;
        rd_sel = reg_select(i_s_axi_araddr);
        if (o_s_axi_rvalid && i_s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = 32'h00000000;
            next_rresp = wdtu_pkg::WDTU_RESP_OKAY;
            if (rd_sel[0]) begin
                next_rdata[wdtu_pkg::WDTU_PS_MSB:wdtu_pkg::WDTU_PS_LSB] = wd_period_select;
                next_rdata[wdtu_pkg::WDTU_SWEN_BIT] = sw_wd_enable;
            end else if (rd_sel[1]) begin
                next_rdata[wdtu_pkg::WDTU_STAT_TO_BIT] = o_timeout_flag_n;
                next_rdata[wdtu_pkg::WDTU_STAT_PD_BIT] = o_powerdown_flag_n;
                next_rdata[wdtu_pkg::WDTU_STAT_SLEEP_BIT] = o_asleep;
                next_rdata[wdtu_pkg::WDTU_STAT_ACTIVE_BIT] = wd_active;
                next_rdata[wdtu_pkg::WDTU_STAT_CNT_MSB:wdtu_pkg::WDTU_STAT_CNT_LSB] = cnt_value;
            end else begin
                next_rresp = wdtu_pkg::WDTU_RESP_SLVERR;
            end
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= wdtu_pkg::WDTU_RESP_OKAY;
        end else begin
            o_s_axi_arready <= next_arready;
            o_s_axi_rvalid <= next_rvalid;
            o_s_axi_rdata <= next_rdata;
            o_s_axi_rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_mode_off;
        (i_wd_mode_cfg == 2'h0) |=> (cnt_value == 23'h000000) && !o_wdt_reset;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("watchdog ran in mode 00");

    property p_mode_on;
        (i_wd_mode_cfg == 2'h3) |-> wd_active;
    endproperty
    a_mode_on: assert property (p_mode_on)
        else $error("mode 11 not active");

    property p_mode_awake;
        (i_wd_mode_cfg == 2'h2) |-> (wd_active == !o_asleep);
    endproperty
    a_mode_awake: assert property (p_mode_awake)
        else $error("mode 10 wrong in sleep state");

    property p_mode_sw;
        (i_wd_mode_cfg == 2'h1) |-> (wd_active == sw_wd_enable);
    endproperty
    a_mode_sw: assert property (p_mode_sw)
        else $error("mode 01 ignores enable bit");

    property p_reset_period;
        $past(i_rst) |-> (wd_period_select == wdtu_pkg::WDTU_PS_RESET)
            && (sw_wd_enable == wdtu_pkg::WDTU_SWEN_RESET);
    endproperty
    a_reset_period: assert property (p_reset_period)
        else $error("wrong period after reset");

    property p_osc_hold;
        (osc_hold && !i_rst) [*3] |-> (cnt_value == 23'h000000) && $past(cnt_value) == 23'h0;
    endproperty
    a_osc_hold: assert property (p_osc_hold)
        else $error("count moved during start-up");

    property p_sleep_wake;
        (cnt_timeout && o_asleep) |=> o_wake && !o_wdt_reset && !o_asleep
            && !o_timeout_flag_n && !o_powerdown_flag_n;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep time-out did not wake");

    property p_zero_bits;
        o_s_axi_rvalid |-> (o_s_axi_rdata[7:6] == 2'h0);
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("bits 7:6 read non-zero");

    property p_awake_reset;
        (cnt_timeout && !o_asleep) |=> o_wdt_reset ##1 !o_wdt_reset;
    endproperty
    a_awake_reset: assert property (p_awake_reset)
        else $error("awake time-out gave no reset pulse");

    property p_sleep_flags;
        (i_sleep_enter && !o_asleep && !cnt_timeout) |=> o_asleep
            && !o_powerdown_flag_n && o_timeout_flag_n && (cnt_value == 23'h0);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("sleep entry flags wrong");

endmodule : wdtu_watchdog

// file: wdtu_core_model.sv
// Core model: turns bench commands into one-cycle core event pulses.
// Assumes commands change just after a rising edge of i_clk.
`timescale 1ns/10ps
module wdtu_core_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Command: 1 clear, 2 sleep, 3 wake
    input wire logic [1:0] i_cmd,
    // Core events
    output logic o_clear,
    output logic o_sleep_enter,
    output logic o_sleep_exit
);
    // Clears are how firmware keeps the watchdog quiet
    always @(posedge i_clk) begin
        o_clear <= !i_rst && i_cmd == 2'h1;
        o_sleep_enter <= !i_rst && i_cmd == 2'h2;
        o_sleep_exit <= !i_rst && i_cmd == 2'h3;
    end
endmodule : wdtu_core_model

// file: wdtu_watchdog_tb_top.sv
// Self-checking bench: registers, modes, periods, clears and sleep.
// Assumes the core model drives the clear and sleep event pins; the bench drives the rest.
`timescale 1ns/10ps
module wdtu_watchdog_tb_top;
    logic i_clk = 1'b0, i_rst = 1'b1, osc = 1'b0, xtal = 1'b0, ofail = 1'b0, osc_startup_timer = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [1:0] mode = 2'h0, cmd = 2'h0, bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, wrst, wake, to_n, pd_n, asleep;
    logic clr, sen, sex;
    int fail_count = 0, num_checks = 0, cyc = 0, ev_rst = 0, ev_wk = 0;
    int n, m_to, m_pd, m_slp;
    int codes[$];
    logic [1:0] tm[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    int te[5] = '{1, 0, 1, 0, 0};
    int tn[5] = '{40, 40, 32, 32, 32};

    wdtu_watchdog DUT (.i_clk(i_clk), .i_rst(i_rst), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .i_low_freq_internal_osc(osc), .i_wd_mode_cfg(mode),
        .i_crystal_mode(xtal), .i_clear_watchdog_instr(clr), .i_sleep_enter(sen),
        .i_sleep_exit(sex), .i_osc_fail(ofail), .i_osc_startup_timer(osc_startup_timer),
        .o_wdt_reset(wrst), .o_wake(wake), .o_timeout_flag_n(to_n),
        .o_powerdown_flag_n(pd_n), .o_asleep(asleep));
    wdtu_core_model core_m (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(cmd), .o_clear(clr),
        .o_sleep_enter(sen), .o_sleep_exit(sex));

    initial forever #20 i_clk = ~i_clk;

    ////////////////////////////////////////
    always @(posedge i_clk) begin
        cyc++;
        if (wrst === 1'b1) ev_rst++;
        if (wake === 1'b1) ev_wk++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic int ratio(input int c);
        return (c <= 18) ? (32 << c) : 32;
    endfunction : ratio

    task automatic wr32(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge i_clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid === 1'b1;
            r = bresp;
            @(posedge i_clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge i_clk);
    endtask : wr32

    task automatic rd32(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge i_clk);
            ha = arvalid && arready;
            hr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge i_clk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge i_clk);
    endtask : rd32

    task automatic chk_stat;
        rd32(4'h4, q, rs);
        check(q & 32'h7, 32'(m_to + 2 * m_pd + 4 * m_slp));
    endtask : chk_stat

    task automatic ticks(input int k);
        repeat (k) begin
            osc <= 1'b1;
            repeat (4) @(posedge i_clk);
            osc <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask : ticks

    // Ticks until a reset or wake event, or the limit
    task automatic run(input int lim, output int k);
        int base;
        base = ev_rst + ev_wk;
        k = 0;
        while (ev_rst + ev_wk == base && k < lim) begin
            ticks(1);
            k++;
        end
    endtask : run

    task automatic core(input logic [1:0] c);
        cmd <= c;
        @(posedge i_clk);
        cmd <= 2'h0;
        repeat (3) @(posedge i_clk);
    endtask : core

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h9d6b));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        m_to = 1;
        m_pd = 1;
        m_slp = 0;
        rd32(4'h0, q, rs);
        check(q, 32'h16);
        chk_stat();
        rd32(4'h8, q, rs);
        check(32'(rs), 32'h2);
        wr32(4'h8, 32'h0, rs);
        check(32'(rs), 32'h2);
        wr32(4'h4, 32'h0, rs);
        check(32'(rs), 32'h0);
        chk_stat();
        wr32(4'h0, 32'hc1, rs);
        check(32'(rs), 32'h0);
        rd32(4'h0, q, rs);
        check(q, 32'h1);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            mode <= tm[i];
            wr32(4'h0, 32'(te[i]), rs);
            core(2'h1);
            run(40, n);
            check(32'(n), 32'(tn[i]));
            check(32'(to_n), 32'(tn[i] == 40));
            core(2'h1);
        end
        check(32'(ev_rst), 32'd3);
        $display("test modes done");
        mode <= 2'h3;
        codes = '{0, 1, $urandom % 4, 19 + $urandom % 13, 31};
        foreach (codes[i]) begin
            wr32(4'h0, 32'(codes[i] << 1), rs);
            core(2'h1);
            run(300, n);
            check(32'(n), 32'(ratio(codes[i])));
        end
        $display("test periods done");
        // Reset in mid-run restores the period code
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd32(4'h0, q, rs);
        check(q, 32'h16);
        wr32(4'h0, 32'h0, rs);
        check(32'(rs), 32'h0);
        for (int s = 0; s < 2; s++) begin
            core(2'h1);
            ticks(20);
            ofail <= (s == 1);
            core((s == 0) ? 2'h1 : 2'h0);
            ofail <= 1'b0;
            run(300, n);
            check(32'(n), 32'd32);
        end
        $display("test clears done");
        core(2'h1);
        mode <= 2'h2;
        core(2'h2);
        m_pd = 0;
        m_slp = 1;
        chk_stat();
        check(32'(asleep), 32'd1);
        run(40, n);
        check(32'(n), 32'd40);
        core(2'h3);
        m_slp = 0;
        chk_stat();
        mode <= 2'h3;
        ticks(20);
        core(2'h2);
        run(300, n);
        check(32'(n), 32'd32);
        m_to = 0;
        chk_stat();
        check(32'(ev_wk), 32'd1);
        core(2'h1);
        xtal <= 1'b1;
        osc_startup_timer <= 1'b1;
        core(2'h2);
        core(2'h3);
        run(40, n);
        check(32'(n), 32'd40);
        osc_startup_timer <= 1'b0;
        run(300, n);
        check(32'(n), 32'd32);
        // Start-up timer without a crystal: no hold, only the sleep-entry and wake clears
        xtal <= 1'b0;
        osc_startup_timer <= 1'b1;
        core(2'h2);
        core(2'h3);
        run(300, n);
        check(32'(n), 32'd32);
        osc_startup_timer <= 1'b0;
        $display("test sleep done");
        close_out();
    end
endmodule : wdtu_watchdog_tb_top
